// File: rtl/osc_ctrl_pkg.sv
// Package with register map, fields, modes and timing for the oscillator block
package osc_ctrl_pkg;
  localparam logic [7:0] EXT_OSC_CTRL_ADDR = 8'hb1;
  localparam logic [7:0] LF_OSC_CTRL_ADDR = 8'he3;
  localparam logic [7:0] EXT_OSC_CTRL_RESET = 8'h00;
  localparam logic [7:0] LF_OSC_CTRL_RESET = 8'h00;
  localparam int LF_EN_BIT = 7;
  localparam int LF_RDY_BIT = 6;
  localparam int LF_TRIM_LSB = 2;
  localparam int LF_DIV_LSB = 0;
  localparam int XVALID_BIT = 7;
  localparam int XMODE_LSB = 4;
  localparam int XRANGE_LSB = 0;
  localparam logic [1:0] LF_DIV8 = 2'h0;
  localparam logic [1:0] LF_DIV4 = 2'h1;
  localparam logic [1:0] LF_DIV2 = 2'h2;
  localparam logic [1:0] LF_DIV1 = 2'h3;
  localparam logic [2:0] XM_CMOS = 3'h2;
  localparam logic [2:0] XM_CMOS_DIV2 = 3'h3;
  localparam logic [2:0] XM_RC = 3'h4;
  localparam logic [2:0] XM_CAP = 3'h5;
  localparam logic [2:0] XM_XTAL = 3'h6;
  localparam logic [2:0] XM_XTAL_DIV2 = 3'h7;
  localparam logic [1:0] SRC_EXT = 2'h1;
  localparam logic [1:0] SRC_LF = 2'h2;
  localparam int CLK_HZ = 10_000_000;
  localparam int LF_SETTLE_US = 100;
  localparam int LF_SETTLE_CYC = (LF_SETTLE_US * (CLK_HZ / 1_000_000));
  localparam int XTAL_SETTLE_US = 1000;
  localparam int XTAL_SETTLE_CYC = (XTAL_SETTLE_US * (CLK_HZ / 1_000_000));
endpackage : osc_ctrl_pkg

// File: rtl/lf_div_if.sv
// Interface between the control top and the post-scaler
`timescale 1ns/100ps
interface lf_div_if;
  logic run;
  logic [1:0] sel;
  logic tick;
  logic out;
  modport ctrl (output run, output sel, output tick, input out);
  modport div (input run, input sel, input tick, output out);
endinterface : lf_div_if

// File: rtl/lf_post_scaler.sv
// Divide-by-1/2/4/8 post-scaler for the low-frequency clock
`timescale 1ns/100ps
module lf_post_scaler (
  input wire logic clk,
  input wire logic rst_n,
  lf_div_if.div dv
);
  typedef struct packed {
    logic [2:0] cnt;
    logic out;
  } ps_s;
  ps_s q, d;

  always_comb begin
    d = q;
    if (!dv.run) begin
      d.cnt = 3'h0;
      d.out = 1'b0;
    end else if (dv.tick) begin
      d.cnt = q.cnt + 3'h1;
      case (dv.sel)
        osc_ctrl_pkg::LF_DIV8: d.out = d.cnt[2];
        osc_ctrl_pkg::LF_DIV4: d.out = d.cnt[1];
        osc_ctrl_pkg::LF_DIV2: d.out = d.cnt[0];
        default: d.out = 1'b1;
      endcase
    end else if (dv.sel == osc_ctrl_pkg::LF_DIV1) begin
      // Divide by 1 passes each raw tick on as a one-cycle pulse
      d.out = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign dv.out = q.out;

  AST_DIV1_PULSE: assert property (
    @(posedge clk) disable iff (!rst_n)
    dv.run && dv.tick && dv.sel == osc_ctrl_pkg::LF_DIV1
    |=> dv.out)
    else $error("Divide by 1 did not follow the tick");
endmodule : lf_post_scaler

// File: rtl/osc_ctrl.sv
// Low-frequency and external oscillator control and status
`timescale 1ns/100ps
// Operation
// - LF control bit 7 enables the low-frequency oscillator.
// - Bits 5-2 are a read/write four-bit trim, about 3% period per step.
// - Divider codes 00, 01, 11 give divide by 8, 4, 1.
// - Divider code 10 gives divide by 2.
// - External bit 7 is read-only crystal valid, only in crystal modes.
// - Mode 00x turns external circuit off; 010 is CMOS clock.
// - Mode 011 is CMOS clock halved.
// - Mode 100 is RC, mode 101 is capacitor.
// - Mode 110 is crystal, 111 is crystal halved.
// - External bit 3 reads zero and ignores writes.
// - Crystal mode takes pins P0.2 and P0.3; RC, C, CMOS take P0.3.
// - Source 01 routes external clock, 10 routes scaled LF clock.
module osc_ctrl #(
  parameter int LF_SETTLE = osc_ctrl_pkg::LF_SETTLE_CYC,
  parameter int XTAL_SETTLE = osc_ctrl_pkg::XTAL_SETTLE_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic [1:0] clk_src_sel,
  input wire logic lf_osc_tick,
  input wire logic ext_clk_edge,
  output logic [1:0] sys_clk_route,
  output logic sys_clk_tick,
  output logic lf_osc_run,
  output logic [3:0] lf_freq_trim,
  output logic ext_osc_enable,
  output logic [2:0] ext_osc_mode_select,
  output logic [2:0] ext_freq_range,
  output logic ext_osc_in_pin_claim,
  output logic ext_osc_out_pin_claim
);
  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic srst_n;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign srst_n = rst_sync_q[1];

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {XS_IDLE, XS_WAIT, XS_VALID} xs_e;
  typedef struct packed {
    logic lf_en;
    logic lf_rdy;
    logic [3:0] trim;
    logic [1:0] div;
    logic [2:0] xmode;
    logic [2:0] xrange;
    logic [13:0] lf_cnt;
    logic [13:0] x_cnt;
    xs_e xs;
    logic half;
    logic [7:0] rdata;
    logic [1:0] route;
    logic tick;
    logic pin_in;
    logic pin_out;
  } st_s;
  st_s q, d;

  // ---------------------------------------------------------------
  // Post-scaler
  // ---------------------------------------------------------------
  lf_div_if dvi ();
  lf_post_scaler u_ps (.clk(core_clk), .rst_n(srst_n), .dv(dvi));
  assign dvi.run = q.lf_en && q.lf_rdy;
  assign dvi.sel = q.div;
  assign dvi.tick = lf_osc_tick;

  function automatic logic is_xtal(input logic [2:0] m);
    is_xtal = m[2] && m[1];
  endfunction : is_xtal

  function automatic logic ext_on(input logic [2:0] m);
    ext_on = m[2] || m[1];
  endfunction : ext_on

  logic xvalid;
  assign xvalid = is_xtal(q.xmode) && q.xs == XS_VALID;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (sfr_wr && sfr_addr == osc_ctrl_pkg::LF_OSC_CTRL_ADDR) begin
      d.lf_en = sfr_wdata[osc_ctrl_pkg::LF_EN_BIT];
      d.trim = sfr_wdata[osc_ctrl_pkg::LF_TRIM_LSB +: 4];
      d.div = sfr_wdata[osc_ctrl_pkg::LF_DIV_LSB +: 2];
    end
    if (sfr_wr && sfr_addr == osc_ctrl_pkg::EXT_OSC_CTRL_ADDR) begin
      d.xmode = sfr_wdata[osc_ctrl_pkg::XMODE_LSB +: 3];
      d.xrange = sfr_wdata[osc_ctrl_pkg::XRANGE_LSB +: 3];
    end
    // LF settle counter
    if (!q.lf_en) begin
      d.lf_cnt = '0;
      d.lf_rdy = 1'b0;
    end else if (q.lf_cnt >= 14'(LF_SETTLE - 1)) begin
      d.lf_rdy = 1'b1;
    end else begin
      d.lf_cnt = q.lf_cnt + 14'h1;
    end
    // Crystal settle sequence
    case (q.xs)
      XS_IDLE: begin
        d.x_cnt = '0;
        if (is_xtal(q.xmode)) d.xs = XS_WAIT;
      end
      XS_WAIT: begin
        if (!is_xtal(q.xmode)) d.xs = XS_IDLE;
        else if (q.x_cnt >= 14'(XTAL_SETTLE - 1)) d.xs = XS_VALID;
        else d.x_cnt = q.x_cnt + 14'h1;
      end
      XS_VALID: begin
        if (!is_xtal(q.xmode)) d.xs = XS_IDLE;
      end
      default: d.xs = XS_IDLE;
    endcase
    // Read data
    d.rdata = 8'h00;
    if (sfr_rd && sfr_addr == osc_ctrl_pkg::LF_OSC_CTRL_ADDR) begin
      d.rdata = {q.lf_en, q.lf_rdy, q.trim, q.div};
    end else if (sfr_rd && sfr_addr == osc_ctrl_pkg::EXT_OSC_CTRL_ADDR) begin
      d.rdata = {xvalid, q.xmode, 1'b0, q.xrange};
    end
    // Pin ownership
    d.pin_in = is_xtal(q.xmode);
    d.pin_out = ext_on(q.xmode);
    // System clock routing
    d.route = clk_src_sel;
    case (clk_src_sel)
      osc_ctrl_pkg::SRC_EXT: begin
        if (ext_clk_edge && ext_on(q.xmode)) begin
          if (q.xmode == osc_ctrl_pkg::XM_CMOS_DIV2
              || q.xmode == osc_ctrl_pkg::XM_XTAL_DIV2) begin
            d.half = ~q.half;
            d.tick = q.half;
          end else begin
            d.tick = 1'b1;
          end
        end
      end
      osc_ctrl_pkg::SRC_LF: d.tick = dvi.out;
      default: d.tick = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge srst_n) begin
    if (!srst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign sfr_rdata = q.rdata;
  assign sys_clk_route = q.route;
  assign sys_clk_tick = q.tick;
  assign lf_osc_run = q.lf_en;
  assign lf_freq_trim = q.trim;
  assign ext_osc_enable = q.pin_out;
  assign ext_osc_mode_select = q.xmode;
  assign ext_freq_range = q.xrange;
  assign ext_osc_in_pin_claim = q.pin_in;
  assign ext_osc_out_pin_claim = q.pin_out;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  AST_LF_EN_WRITE: assert property (
    @(posedge core_clk) disable iff (!srst_n)
    sfr_wr && sfr_addr == osc_ctrl_pkg::LF_OSC_CTRL_ADDR
    |=> lf_osc_run == $past(sfr_wdata[7]))
    else $error("LF enable did not follow write");
  AST_LF_RDY_CLEAR: assert property (
    @(posedge core_clk) disable iff (!srst_n)
    !q.lf_en |=> !q.lf_rdy)
    else $error("LF ready stayed set while disabled");
  AST_LF_RDY_LATE: assert property (
    @(posedge core_clk) disable iff (!srst_n)
    $rose(q.lf_en) |-> !q.lf_rdy [*2])
    else $error("LF ready rose too soon");
  AST_TRIM_WRITE: assert property (
    @(posedge core_clk) disable iff (!srst_n)
    sfr_wr && sfr_addr == osc_ctrl_pkg::LF_OSC_CTRL_ADDR
    |=> lf_freq_trim == $past(sfr_wdata[5:2]))
    else $error("Trim did not follow write");
  AST_RSVD_ZERO: assert property (
    @(posedge core_clk) disable iff (!srst_n)
    sfr_rd && sfr_addr == osc_ctrl_pkg::EXT_OSC_CTRL_ADDR |=> !sfr_rdata[3])
    else $error("Reserved bit read as one");
  AST_XVALID_MODE: assert property (
    @(posedge core_clk) disable iff (!srst_n)
    sfr_rd && sfr_addr == osc_ctrl_pkg::EXT_OSC_CTRL_ADDR
    && !is_xtal(q.xmode) |=> !sfr_rdata[7])
    else $error("Crystal valid set outside crystal mode");
  AST_PIN_CLAIM: assert property (
    @(posedge core_clk) disable iff (!srst_n)
    q.xmode == osc_ctrl_pkg::XM_RC ##1 q.xmode == osc_ctrl_pkg::XM_RC
    |-> ext_osc_out_pin_claim && !ext_osc_in_pin_claim)
    else $error("RC mode pin claim wrong");
  AST_OFF_NO_TICK: assert property (
    @(posedge core_clk) disable iff (!srst_n)
    clk_src_sel == osc_ctrl_pkg::SRC_EXT && !ext_on(q.xmode)
    |=> !sys_clk_tick)
    else $error("External tick while circuit off");
  AST_DIV2_HALF: assert property (
    @(posedge core_clk) disable iff (!srst_n)
    sys_clk_tick && $past(clk_src_sel) == osc_ctrl_pkg::SRC_EXT
    && $past(q.xmode) == osc_ctrl_pkg::XM_CMOS_DIV2 |-> $past(q.half))
    else $error("Divide by 2 tick on wrong phase");
  AST_ROUTE_FOLLOW: assert property (
    @(posedge core_clk) disable iff (!srst_n)
    1'b1 |=> sys_clk_route == $past(clk_src_sel))
    else $error("Clock route did not follow the selector");
endmodule : osc_ctrl

// File: test/ext_clock_source.sv
// Behavioural external clock source and low-frequency oscillator core
`timescale 1ns/100ps
module ext_clock_source (
  input wire logic core_clk,
  input wire logic lf_run,
  input wire logic ext_on,
  output logic lf_osc_tick,
  output logic ext_clk_edge
);
  logic [1:0] lf_ph_q;
  logic [1:0] ext_ph_q;
  initial begin
    lf_ph_q = 2'h0;
    ext_ph_q = 2'h0;
    lf_osc_tick = 1'b0;
    ext_clk_edge = 1'b0;
  end
  // Edges only while the source is powered, otherwise quiet
  always @(posedge core_clk) begin
    lf_ph_q <= lf_ph_q + 2'h1;
    ext_ph_q <= (ext_ph_q == 2'h2) ? 2'h0 : ext_ph_q + 2'h1;
    lf_osc_tick <= lf_run && (lf_ph_q == 2'h0);
    ext_clk_edge <= ext_on && (ext_ph_q == 2'h0);
  end
endmodule : ext_clock_source

// File: test/tb_lf_and_external_osc_control.sv
// Self-checking bench for the oscillator control block
`timescale 1ns/100ps
module tb_lf_and_external_osc_control;
  localparam int LF_S = 8;
  localparam int XT_S = 16;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic [1:0] clk_src_sel = 2'h0;
  logic [7:0] sfr_rdata, rd;
  logic [1:0] sys_clk_route;
  logic sys_clk_tick, lf_osc_run, lf_osc_tick, ext_clk_edge, ext_osc_enable;
  logic in_claim, out_claim, tick_prev;
  logic [3:0] lf_freq_trim;
  logic [2:0] mode, range;
  int miscompares = 0;
  int n_tests = 0;
  int rises = 0;
  int cycles = 0;
  always #50 core_clk = ~core_clk;
  osc_ctrl #(.LF_SETTLE(LF_S), .XTAL_SETTLE(XT_S)) osc_ctrl_inst (
    .core_clk(core_clk), .rst_n(rst_n), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .clk_src_sel(clk_src_sel), .lf_osc_tick(lf_osc_tick),
    .ext_clk_edge(ext_clk_edge), .sys_clk_route(sys_clk_route),
    .sys_clk_tick(sys_clk_tick), .lf_osc_run(lf_osc_run),
    .lf_freq_trim(lf_freq_trim), .ext_osc_enable(ext_osc_enable),
    .ext_osc_mode_select(mode), .ext_freq_range(range),
    .ext_osc_in_pin_claim(in_claim), .ext_osc_out_pin_claim(out_claim));
  ext_clock_source ext_clock_source_inst (.core_clk(core_clk),
    .lf_run(lf_osc_run), .ext_on(ext_osc_enable),
    .lf_osc_tick(lf_osc_tick), .ext_clk_edge(ext_clk_edge));
  // ----------------------------------------
  // Tick counting and timeout
  // ----------------------------------------
  // Rises are counted on the falling edge, away from the stimulus edge
  always @(negedge core_clk) begin
    if (sys_clk_tick === 1'b1 && tick_prev !== 1'b1) rises++;
    tick_prev = sys_clk_tick;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sfr_wr <= 1'b1;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge core_clk);
    sfr_wr <= 1'b0;
  endtask : sfr_write
  task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    sfr_rd <= 1'b1;
    sfr_addr <= a;
    @(posedge core_clk);
    sfr_rd <= 1'b0;
    #1 d = sfr_rdata;
  endtask : sfr_read
  task automatic count_ticks(input logic [1:0] src, input int n, input int e);
    @(posedge core_clk);
    clk_src_sel <= src;
    repeat (4) @(posedge core_clk);
    rises = 0;
    repeat (n) @(posedge core_clk);
    check({15'h0, rises >= e - 1 && rises <= e + 1}, 16'h1);
    check({14'h0, sys_clk_route}, {14'h0, src});
    clk_src_sel <= 2'h0;
  endtask : count_ticks
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset;
    sfr_read(8'he3, rd);
    check(rd, 8'h00);
    sfr_read(8'hb1, rd);
    check(rd, 8'h00);
    sfr_read(8'h55, rd);
    check(rd, 8'h00);
  endtask : test_reset
  task automatic test_lf;
    sfr_write(8'he3, 8'hff);
    sfr_read(8'he3, rd);
    check(rd, 8'hbf);
    check({lf_osc_run, 3'h0, lf_freq_trim}, 8'h8f);
    repeat (LF_S + 6) @(posedge core_clk);
    sfr_read(8'he3, rd);
    check(rd, 8'hff);
    sfr_write(8'he3, 8'h28);
    sfr_read(8'he3, rd);
    check(rd, 8'h28);
    check({lf_osc_run, 3'h0, lf_freq_trim}, 8'h0a);
  endtask : test_lf
  task automatic test_div;
    for (int d = 0; d < 4; d++) begin
      sfr_write(8'he3, 8'h80 | d[7:0]);
      repeat (LF_S + 6) @(posedge core_clk);
      count_ticks(2'h2, 256, 8 << d);
    end
  endtask : test_div
  task automatic test_ext;
    logic en;
    for (int m = 0; m < 8; m++) begin
      en = (m >= 2);
      sfr_write(8'hb1, {1'b1, m[2:0], 1'b1, 3'h5});
      sfr_read(8'hb1, rd);
      check(rd, {m == 7, m[2:0], 1'b0, 3'h5});
      check({ext_osc_enable, mode, range},
        {en, m[2:0], 3'h5});
      check({in_claim, out_claim}, {m >= 6, en});
      count_ticks(2'h1, 48, !en ? 0 : (m == 3 || m == 7) ? 8 : 16);
      if (m >= 6) begin
        repeat (XT_S + 6) @(posedge core_clk);
        sfr_read(8'hb1, rd);
        check(rd, {1'b1, m[2:0], 1'b0, 3'h5});
      end
    end
    count_ticks(2'h3, 48, 0);
    sfr_write(8'hb1, 8'h42);
    sfr_read(8'hb1, rd);
    check(rd, 8'h42);
  endtask : test_ext
  task automatic report_and_stop;
    $display("Checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    test_reset();
    test_lf();
    test_div();
    test_ext();
    report_and_stop();
  end
endmodule : tb_lf_and_external_osc_control
